// file: common/mmt_pkg.sv
// package of constants and carriers shared by the memory map and table read block
package mmt_pkg;

  localparam logic [15:0] RESET_VECTOR        = 16'h0000;
  localparam int          PROG_DEPTH_MIN      = 4096;
  localparam int          PROG_DEPTH_MAX      = 8192;
  localparam int          PROG_WIDTH_MIN      = 8;
  localparam int          PROG_WIDTH_MAX      = 16;
  localparam int          PAGE_WORDS          = 256;

  localparam logic [7:0]  OFS_IND_FIRST       = 8'h00;
  localparam logic [7:0]  OFS_PTR_FIRST       = 8'h01;
  localparam logic [7:0]  OFS_IND_SECOND      = 8'h02;
  localparam logic [7:0]  OFS_PTR_SECOND_LO   = 8'h03;
  localparam logic [7:0]  OFS_PTR_SECOND_HI   = 8'h04;
  localparam logic [7:0]  OFS_TBL_PTR_LO      = 8'h07;
  localparam logic [7:0]  OFS_TBL_HOLD        = 8'h08;
  localparam logic [7:0]  OFS_TBL_PTR_HI      = 8'h09;
  localparam logic [7:0]  OFS_IND_THIRD       = 8'h0c;
  localparam logic [7:0]  OFS_PTR_THIRD_LO    = 8'h0d;
  localparam logic [7:0]  OFS_PTR_THIRD_HI    = 8'h0e;
  localparam logic [7:0]  OFS_NVM_CTRL        = 8'h40;
  localparam logic [7:0]  OFS_GP_BASE         = 8'h80;

  localparam logic [1:0]  SECTOR_ZERO         = 2'h0;
  localparam logic [1:0]  NVM_CTRL_SECTOR     = 2'h1;
  localparam int          GP_SECTORS          = 3;
  localparam int          GP_BYTES_PER_SECTOR = 128;

  localparam logic [7:0]  SFR_RESET           = 8'h00;
  localparam logic [7:0]  NVM_CTRL_RESET      = 8'h00;
  localparam logic [7:0]  NVM_CTRL_WR_MASK    = 8'h0f;
  localparam logic [7:0]  UNUSED_READ         = 8'h00;

  localparam logic [4:0]  SER_ADDR_LAST       = 5'h0f;
  localparam logic [4:0]  SER_FRAME_LAST      = 5'h1f;
  localparam int          SER_READ_FLAG       = 15;

  typedef enum logic [1:0] {
    KIND_CURRENT,
    KIND_ANY_SECTOR,
    KIND_CURRENT_LAST_PAGE,
    KIND_ANY_SECTOR_LAST_PAGE
  } mmt_tbl_kind_type;

  typedef enum logic {TBL_IDLE, TBL_FETCH} mmt_tbl_state_type;

  typedef struct packed {
    logic        en;
    logic        load;
    logic [15:0] pc;
  } mmt_fetch_req_type;

  typedef struct packed {
    logic             req;
    mmt_tbl_kind_type kind;
    logic [1:0]       sector;
    logic [7:0]       offset;
  } mmt_tbl_req_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bit_set;
    logic       bit_clr;
    logic [2:0] bit_sel;
    logic [1:0] sector;
    logic [7:0] offset;
    logic [7:0] wdata;
  } mmt_dm_req_type;

  typedef struct packed {
    logic       noop;
    logic [1:0] sector;
    logic [7:0] offset;
  } mmt_loc_type;

endpackage : mmt_pkg

// file: hw/mmt_prog_mem.sv
// program memory array with a fetch/table port and a serial programming port
`timescale 1ns/100ps
module mmt_prog_mem
  import mmt_pkg::*;
#(
  parameter int DEPTH = 8192,
  parameter int WIDTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic [AW-1:0]    rd_a_addr,
  output logic      [15:0]      rd_a_data,
  input  wire logic [AW-1:0]    rd_b_addr,
  output logic      [15:0]      rd_b_data,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [15:0]      wr_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } mmt_pm_state_type;

  mmt_pm_state_type state_reg;
  mmt_pm_state_type state_next;

  // narrow words pad with zeros so unused high bits read as 0
  assign rd_a_data = 16'(state_reg.mem[rd_a_addr]);
  assign rd_b_data = 16'(state_reg.mem[rd_b_addr]);

  // contents survive reset, as flash would
  always_comb begin
    state_next = state_reg;
    if (wr_en) begin
      state_next.mem[wr_addr] = wr_data[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

endmodule : mmt_prog_mem

// file: hw/mmt_gp_ram.sv
// general purpose data storage, one byte array per sector
`timescale 1ns/100ps
module mmt_gp_ram
  import mmt_pkg::*;
#(
  parameter int SECTORS = GP_SECTORS
) (
  input  wire logic       clk,
  input  wire logic [1:0] rd_sector,
  input  wire logic [6:0] rd_index,
  output logic      [7:0] rd_data,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_sector,
  input  wire logic [6:0] wr_index,
  input  wire logic [7:0] wr_data
);

  typedef struct packed {
    logic [SECTORS-1:0][GP_BYTES_PER_SECTOR-1:0][7:0] mem;
  } mmt_gp_state_type;

  mmt_gp_state_type state_reg;
  mmt_gp_state_type state_next;

  assign rd_data = (int'(rd_sector) < SECTORS) ? state_reg.mem[rd_sector][rd_index] : UNUSED_READ;

  always_comb begin
    state_next = state_reg;
    if (wr_en && (int'(wr_sector) < SECTORS)) begin
      state_next.mem[wr_sector][wr_index] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

endmodule : mmt_gp_ram

// file: hw/mmt_top.sv
// memory map, sectored data memory, table read engine and serial program access
`timescale 1ns/100ps
// Overview of operation
// - program memory of 8- to 16-bit words, 4K-8K deep
// - fetch starts at word zero after reset
// - table data addressed by separate table pointer
// - both pointer bytes form full table address
// - short forms write sector 0; long any
// - low byte to destination, high to hold
// - unused high bits of hold read zero
// - last-page forms offset from last page start
// - every table read takes two cycles
// - hold register readable and writable by software
// - serial programming over one data, one clock pin
// - debug data pin bidirectional, debug clock input
// - bytes, sectors; registers from 00H, storage 80H
// - registers shared; control at 40H sector 1
// - 384 storage bytes, 80H-FFH in sectors 0-2
// - storage read/write; some register bits protected
// - single bit set and clear keep others
// - unused register locations read 00H
// - first pointer sector 0; others select sector
module mmt_top
  import mmt_pkg::*;
#(
  parameter int PROG_DEPTH = 8192,
  parameter int PROG_WIDTH = 16
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire mmt_fetch_req_type fetch,
  output logic      [15:0]       instr_word,
  output logic                   instr_valid,
  output logic      [15:0]       fetch_addr,
  output logic                   fetch_stall,
  input  wire mmt_tbl_req_type   tbl,
  output logic                   tbl_done,
  input  wire mmt_dm_req_type    dm,
  output logic      [7:0]        dm_rdata,
  output logic                   dm_rvalid,
  output logic      [7:0]        nvm_ctrl,
  input  wire logic              prog_mode,
  input  wire logic              prog_serial_clk,
  input  wire logic              prog_serial_dio_in,
  output logic                   prog_serial_dio_out,
  output logic                   prog_serial_dio_oe,
  input  wire logic              debug_mode,
  input  wire logic              debug_clk,
  input  wire logic              debug_dio_in,
  output logic                   debug_dio_out,
  output logic                   debug_dio_oe
);

  localparam int AW = $clog2(PROG_DEPTH);
  localparam logic [AW-1:0] LAST_PAGE_BASE = AW'(PROG_DEPTH - PAGE_WORDS);

  generate
    if (PROG_DEPTH < PROG_DEPTH_MIN || PROG_DEPTH > PROG_DEPTH_MAX ||
        (PROG_DEPTH & (PROG_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("program depth must be a power of two from 4096 to 8192");
    end
    if (PROG_WIDTH < PROG_WIDTH_MIN || PROG_WIDTH > PROG_WIDTH_MAX) begin : g_bad_width
      $error("program word width must be 8 to 16 bits");
    end
  endgenerate

  typedef struct packed {
    mmt_tbl_state_type tstate;
    mmt_tbl_kind_type  kind;
    logic [1:0]        dsec;
    logic [7:0]        doff;
    logic [7:0]        ptr_first;
    logic [7:0]        ptr_second_lo;
    logic [7:0]        ptr_second_hi;
    logic [7:0]        ptr_third_lo;
    logic [7:0]        ptr_third_hi;
    logic [7:0]        table_ptr_low;
    logic [7:0]        table_ptr_high;
    logic [7:0]        table_high_byte_hold;
    logic [7:0]        nvm;
    logic [AW-1:0]     faddr;
    logic [15:0]       instr;
    logic              ivalid;
    logic [7:0]        rdata;
    logic              rvalid;
    logic [1:0]        pclk_s;
    logic [1:0]        pdio_s;
    logic [1:0]        dclk_s;
    logic [1:0]        ddio_s;
    logic              sclk_d;
    logic [4:0]        scnt;
    logic [15:0]       saddr;
    logic [15:0]       sdata;
    logic              srd;
    logic              sload;
    logic              pm_we;
  } mmt_top_state_type;

  mmt_top_state_type state_reg;
  mmt_top_state_type state_next;

  logic          tbl_active;
  logic [AW-1:0] tbl_addr;
  logic [AW-1:0] pm_a_addr;
  logic [15:0]   pm_a_data;
  logic [15:0]   pm_b_data;
  mmt_loc_type   core_loc;
  mmt_loc_type   tbl_loc;
  mmt_loc_type   wr_loc;
  logic [7:0]    gp_rdata;
  logic [7:0]    rd_val;
  logic          core_wr;
  logic          wr_go;
  logic [7:0]    wr_byte;
  logic          gp_we;
  logic          ser_active;
  logic          ser_drive;

  // indirect ports redirect through their pointer; a pointer aimed at a port does nothing
  function automatic mmt_loc_type resolve(input logic [1:0] sec, input logic [7:0] ofs,
                                          input mmt_top_state_type s);
    mmt_loc_type loc;
    loc.noop   = 1'b0;
    loc.sector = sec;
    loc.offset = ofs;
    unique case (ofs)
      OFS_IND_FIRST: begin
        loc.sector = SECTOR_ZERO;
        loc.offset = s.ptr_first;
      end
      OFS_IND_SECOND: begin
        loc.sector = s.ptr_second_hi[1:0];
        loc.offset = s.ptr_second_lo;
      end
      OFS_IND_THIRD: begin
        loc.sector = s.ptr_third_hi[1:0];
        loc.offset = s.ptr_third_lo;
      end
      default: begin
      end
    endcase
    if (loc.offset == OFS_IND_FIRST || loc.offset == OFS_IND_SECOND ||
        loc.offset == OFS_IND_THIRD) begin
      loc.noop = 1'b1;
    end
    return loc;
  endfunction : resolve

  // special function registers other than the control register read the same in every sector, unused ones as zero
  function automatic logic [7:0] sfr_read(input mmt_loc_type loc, input mmt_top_state_type s);
    logic [7:0] v;
    v = UNUSED_READ;
    unique case (loc.offset)
      OFS_PTR_FIRST:     v = s.ptr_first;
      OFS_PTR_SECOND_LO: v = s.ptr_second_lo;
      OFS_PTR_SECOND_HI: v = s.ptr_second_hi;
      OFS_PTR_THIRD_LO:  v = s.ptr_third_lo;
      OFS_PTR_THIRD_HI:  v = s.ptr_third_hi;
      OFS_TBL_PTR_LO:    v = s.table_ptr_low;
      OFS_TBL_PTR_HI:    v = s.table_ptr_high;
      OFS_TBL_HOLD:      v = s.table_high_byte_hold;
      OFS_NVM_CTRL:      v = (loc.sector == NVM_CTRL_SECTOR) ? s.nvm : UNUSED_READ;
      default:           v = UNUSED_READ;
    endcase
    return v;
  endfunction : sfr_read

  assign tbl_active = (state_reg.tstate == TBL_FETCH);

  // full pointer pair, or low pointer as offset into the last page
  always_comb begin
    tbl_addr = AW'({state_reg.table_ptr_high, state_reg.table_ptr_low});
    if (state_reg.kind == KIND_CURRENT_LAST_PAGE ||
        state_reg.kind == KIND_ANY_SECTOR_LAST_PAGE) begin
      tbl_addr = LAST_PAGE_BASE + AW'(state_reg.table_ptr_low);
    end
  end

  // the table word takes the program port in its second cycle
  assign pm_a_addr = tbl_active ? tbl_addr :
                     (fetch.load ? fetch.pc[AW-1:0] : state_reg.faddr);

  assign core_loc = resolve(dm.sector, dm.offset, state_reg);
  assign tbl_loc  = resolve(state_reg.dsec, state_reg.doff, state_reg);
  assign rd_val   = core_loc.noop ? UNUSED_READ :
                    (core_loc.offset >= OFS_GP_BASE) ? gp_rdata :
                    sfr_read(core_loc, state_reg);

  assign core_wr = (dm.wr || dm.bit_set || dm.bit_clr) && !tbl_active;
  assign wr_go   = tbl_active || core_wr;
  assign wr_loc  = tbl_active ? tbl_loc : core_loc;

  always_comb begin
    wr_byte = dm.wdata;
    if (tbl_active) begin
      wr_byte = pm_a_data[7:0];
    end else if (dm.bit_set) begin
      wr_byte = rd_val | (8'h01 << dm.bit_sel);
    end else if (dm.bit_clr) begin
      wr_byte = rd_val & ~(8'h01 << dm.bit_sel);
    end
  end

  assign gp_we = wr_go && !wr_loc.noop && (wr_loc.offset >= OFS_GP_BASE);

  assign ser_active = prog_mode || debug_mode;
  assign ser_drive  = ser_active && state_reg.srd && (state_reg.scnt > SER_ADDR_LAST);

  always_comb begin
    logic sclk;
    logic din;
    state_next        = state_reg;
    sclk              = prog_mode ? state_reg.pclk_s[1] : state_reg.dclk_s[1];
    din               = prog_mode ? state_reg.pdio_s[1] : state_reg.ddio_s[1];
    state_next.ivalid = 1'b0;
    state_next.rvalid = 1'b0;
    state_next.pm_we  = 1'b0;
    state_next.sload  = 1'b0;

    // instruction fetch, held while the table word owns the port
    if (fetch.en && !tbl_active) begin
      state_next.instr  = pm_a_data;
      state_next.ivalid = 1'b1;
      state_next.faddr  = pm_a_addr + AW'(1);
    end

    // table read: capture in the first cycle, transfer in the second
    unique case (state_reg.tstate)
      TBL_IDLE: begin
        if (tbl.req) begin
          state_next.tstate = TBL_FETCH;
          state_next.kind   = tbl.kind;
          state_next.doff   = tbl.offset;
          state_next.dsec   = tbl.sector;
          if (tbl.kind == KIND_CURRENT || tbl.kind == KIND_CURRENT_LAST_PAGE) begin
            state_next.dsec = SECTOR_ZERO;
          end
        end
      end
      TBL_FETCH: begin
        state_next.tstate = TBL_IDLE;
      end
    endcase

    // core read answers one cycle later from a flip-flop
    if (dm.rd) begin
      state_next.rdata  = rd_val;
      state_next.rvalid = 1'b1;
    end

    // register writes; unlisted locations ignore writes
    if (wr_go && !wr_loc.noop) begin
      unique case (wr_loc.offset)
        OFS_PTR_FIRST:     state_next.ptr_first = wr_byte;
        OFS_PTR_SECOND_LO: state_next.ptr_second_lo = wr_byte;
        OFS_PTR_SECOND_HI: state_next.ptr_second_hi = wr_byte;
        OFS_PTR_THIRD_LO:  state_next.ptr_third_lo = wr_byte;
        OFS_PTR_THIRD_HI:  state_next.ptr_third_hi = wr_byte;
        OFS_TBL_PTR_LO:    state_next.table_ptr_low = wr_byte;
        OFS_TBL_PTR_HI:    state_next.table_ptr_high = wr_byte;
        OFS_TBL_HOLD:      state_next.table_high_byte_hold = wr_byte;
        OFS_NVM_CTRL: begin
          if (wr_loc.sector == NVM_CTRL_SECTOR) begin
            // upper bits are status owned by the nonvolatile engine
            state_next.nvm = (state_reg.nvm & ~NVM_CTRL_WR_MASK) |
                             (wr_byte & NVM_CTRL_WR_MASK);
          end
        end
        default: begin
        end
      endcase
    end

    // high byte lands last so it wins if the destination was the hold register
    if (tbl_active) begin
      state_next.table_high_byte_hold = pm_a_data[15:8];
    end

    // serial program access: 16 address bits then 16 data bits, msb first
    state_next.pclk_s = {state_reg.pclk_s[0], prog_serial_clk};
    state_next.pdio_s = {state_reg.pdio_s[0], prog_serial_dio_in};
    state_next.dclk_s = {state_reg.dclk_s[0], debug_clk};
    state_next.ddio_s = {state_reg.ddio_s[0], debug_dio_in};
    state_next.sclk_d = sclk;
    if (state_reg.sload) begin
      state_next.sdata = pm_b_data;
    end
    if (!ser_active) begin
      state_next.scnt = 5'h00;
      state_next.srd  = 1'b0;
    end else if (sclk && !state_reg.sclk_d) begin
      state_next.scnt = (state_reg.scnt == SER_FRAME_LAST) ? 5'h00 : state_reg.scnt + 5'h01;
      if (state_reg.scnt <= SER_ADDR_LAST) begin
        state_next.saddr = {state_reg.saddr[14:0], din};
        if (state_reg.scnt == SER_ADDR_LAST) begin
          state_next.srd   = state_reg.saddr[SER_READ_FLAG - 1];
          state_next.sload = state_reg.saddr[SER_READ_FLAG - 1];
        end
      end else if (state_reg.srd) begin
        state_next.sdata = {state_reg.sdata[14:0], 1'b0};
      end else begin
        state_next.sdata = {state_reg.sdata[14:0], din};
        if (state_reg.scnt == SER_FRAME_LAST) begin
          state_next.pm_we = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg                      <= '0;
      state_reg.tstate               <= TBL_IDLE;
      state_reg.faddr                <= RESET_VECTOR[AW-1:0];
      state_reg.ptr_first            <= SFR_RESET;
      state_reg.ptr_second_lo        <= SFR_RESET;
      state_reg.ptr_second_hi        <= SFR_RESET;
      state_reg.ptr_third_lo         <= SFR_RESET;
      state_reg.ptr_third_hi         <= SFR_RESET;
      state_reg.table_ptr_low        <= SFR_RESET;
      state_reg.table_ptr_high       <= SFR_RESET;
      state_reg.table_high_byte_hold <= SFR_RESET;
      state_reg.nvm                  <= NVM_CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  mmt_prog_mem #(
    .DEPTH (PROG_DEPTH),
    .WIDTH (PROG_WIDTH)
  ) u_prog_mem (
    .clk       (clk),
    .rd_a_addr (pm_a_addr),
    .rd_a_data (pm_a_data),
    .rd_b_addr (state_reg.saddr[AW-1:0]),
    .rd_b_data (pm_b_data),
    .wr_en     (state_reg.pm_we),
    .wr_addr   (state_reg.saddr[AW-1:0]),
    .wr_data   (state_reg.sdata)
  );

  mmt_gp_ram #(
    .SECTORS (GP_SECTORS)
  ) u_gp_ram (
    .clk       (clk),
    .rd_sector (core_loc.sector),
    .rd_index  (core_loc.offset[6:0]),
    .rd_data   (gp_rdata),
    .wr_en     (gp_we),
    .wr_sector (wr_loc.sector),
    .wr_index  (wr_loc.offset[6:0]),
    .wr_data   (wr_byte)
  );

  assign instr_word          = state_reg.instr;
  assign instr_valid         = state_reg.ivalid;
  assign fetch_addr          = 16'(state_reg.faddr);
  assign fetch_stall         = tbl_active;
  assign tbl_done            = tbl_active;
  assign dm_rdata            = state_reg.rdata;
  assign dm_rvalid           = state_reg.rvalid;
  assign nvm_ctrl            = state_reg.nvm;
  assign prog_serial_dio_out = state_reg.sdata[15];
  assign prog_serial_dio_oe  = ser_drive && prog_mode;
  assign debug_dio_out       = state_reg.sdata[15];
  assign debug_dio_oe        = ser_drive && !prog_mode;

endmodule : mmt_top

// file: verification/mmt_chk_sva.sv
// assertion checker watching the ports of the memory map and table read block
`timescale 1ns/100ps
module mmt_chk
  import mmt_pkg::*;
#(
  parameter int PROG_DEPTH = 8192,
  parameter int PROG_WIDTH = 16
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire mmt_fetch_req_type fetch,
  input wire logic [15:0]       instr_word,
  input wire logic              instr_valid,
  input wire logic [15:0]       fetch_addr,
  input wire logic              fetch_stall,
  input wire mmt_tbl_req_type   tbl,
  input wire logic              tbl_done,
  input wire mmt_dm_req_type    dm,
  input wire logic              dm_rvalid,
  input wire logic [7:0]        nvm_ctrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_tbl_done_next: assert property (tbl.req && !fetch_stall |=> tbl_done)
    else $error("table transfer cycle did not follow the request");
  a_done_single: assert property (tbl_done |=> !tbl_done)
    else $error("table transfer cycle lasted more than one cycle");
  a_stall_in_xfer: assert property (tbl_done |-> fetch_stall)
    else $error("fetch not held during table transfer");
  a_no_fetch_held: assert property (fetch_stall |=> !instr_valid)
    else $error("instruction fetched while program port busy");
  a_fetch_answer: assert property (fetch.en && !fetch_stall |=> instr_valid)
    else $error("fetch got no word one cycle later");
  a_fetch_step: assert property (fetch.en && !fetch.load && !fetch_stall |=>
    fetch_addr == $past(fetch_addr) + 16'h1)
    else $error("sequential fetch address did not advance by one");
  a_reset_vector: assert property ($fell(srst) |-> fetch_addr == RESET_VECTOR)
    else $error("fetch address not at reset vector after reset");
  a_rd_answer: assert property (dm.rd |=> dm_rvalid)
    else $error("data read got no answer");
  a_no_spurious: assert property (!dm.rd |=> !dm_rvalid)
    else $error("read answer without a read");
  a_nvm_upper: assert property (nvm_ctrl[7:4] == 4'h0)
    else $error("protected control bits changed");
  a_narrow_word: assert property (instr_valid |-> (instr_word >> PROG_WIDTH) == 16'h0)
    else $error("unused upper word bits not zero");
endmodule : mmt_chk

// file: verification/mmt_core_model.sv
// behavioural model of the instruction core driving the fetch port
`timescale 1ns/100ps
module mmt_core_model
  import mmt_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              run,
  input  wire logic              jump,
  input  wire logic [15:0]       jump_pc,
  input  wire logic              instr_valid,
  output mmt_fetch_req_type      fetch,
  output int                     taken
);
  // request stays up through a stall, so the core simply retries
  assign fetch = '{en: run, load: jump, pc: jump_pc};
  // table reads come from main code only, so the hold register is never shared
  always_ff @(posedge clk) begin
    taken <= srst ? 0 : taken + int'(instr_valid);
  end
endmodule : mmt_core_model

// file: verification/tb_top.sv
// self-checking testbench for the memory map and table read block
`timescale 1ns/100ps
module tb_top import mmt_pkg::*;;
  localparam int PROG_DEPTH = 4096;
  localparam int PROG_WIDTH = 12;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              run = 1'b0;
  logic              jump = 1'b0;
  logic [15:0]       jump_pc = 16'h0;
  mmt_fetch_req_type fetch;
  mmt_tbl_req_type   tbl = '0;
  mmt_dm_req_type    dm = '0;
  logic [15:0]       instr_word, fetch_addr;
  logic              instr_valid, fetch_stall, tbl_done, dm_rvalid;
  logic [7:0]        dm_rdata, nvm_ctrl;
  logic              prog_mode = 1'b0, dbg_mode = 1'b0, pclk = 1'b0, pdio = 1'b0;
  logic              p_out, p_oe, d_out, d_oe, prog_in, dbg_in;
  int                taken, n_fail = 0, comparisons = 0;
  logic [15:0]       words [3] = '{16'h1abc, 16'h5f5a, 16'h0e77};
  logic [15:0]       addrs [3] = '{16'h0000, 16'h0106, 16'h0f06};

  // wire level of the shared data pins from the device's enable alone, else the bench's pdio
  assign prog_in = p_oe ? p_out : pdio;
  assign dbg_in  = d_oe ? d_out : pdio;
  always #5 clk = ~clk;

  mmt_top #(.PROG_DEPTH(PROG_DEPTH), .PROG_WIDTH(PROG_WIDTH)) uut (
    .clk(clk), .srst(srst), .fetch(fetch), .instr_word(instr_word), .instr_valid(instr_valid),
    .fetch_addr(fetch_addr), .fetch_stall(fetch_stall), .tbl(tbl), .tbl_done(tbl_done),
    .dm(dm), .dm_rdata(dm_rdata), .dm_rvalid(dm_rvalid), .nvm_ctrl(nvm_ctrl),
    .prog_mode(prog_mode), .prog_serial_clk(pclk), .prog_serial_dio_in(prog_in),
    .prog_serial_dio_out(p_out), .prog_serial_dio_oe(p_oe), .debug_mode(dbg_mode),
    .debug_clk(pclk), .debug_dio_in(dbg_in), .debug_dio_out(d_out), .debug_dio_oe(d_oe));
  mmt_core_model core (.clk(clk), .srst(srst), .run(run), .jump(jump), .jump_pc(jump_pc),
    .instr_valid(instr_valid), .fetch(fetch), .taken(taken));

  function automatic logic [15:0] msk(input logic [15:0] w);
    return w & ((16'h1 << PROG_WIDTH) - 16'h1);
  endfunction : msk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic dmop(input logic [3:0] op, input logic [2:0] b, input logic [1:0] s,
                      input logic [7:0] o, input logic [7:0] d);
    step(1);  // idle edge between requests
    dm = '{op[3], op[2], op[1], op[0], b, s, o, d};
    step(1);
    dm = '0;
  endtask : dmop
  task automatic wr(input logic [1:0] s, input logic [7:0] o, input logic [7:0] d);
    dmop(4'h4, 3'h0, s, o, d);
  endtask : wr
  task automatic rdc(input logic [1:0] s, input logic [7:0] o, input logic [7:0] e);
    dmop(4'h8, 3'h0, s, o, 8'h00);
    chk(32'({dm_rvalid, dm_rdata}), 32'({1'b1, e}));
  endtask : rdc
  // address frame msb first with read flag on top, then data; a read judges the pin
  task automatic ser_frame(input logic m, input logic r, input logic [15:0] a,
                           input logic [15:0] d);
    logic [31:0] f;
    f = {r, a[14:0], d};
    {prog_mode, dbg_mode} = {!m, m};
    for (int i = 31; i >= 0; i--) begin
      pdio = f[i];
      step(5);
      if (r && i < 16) begin
        chk(32'({p_oe, d_oe, m ? d_out : p_out}), 32'({!m, m, d[i]}));
      end
      pclk = 1'b1;
      step(5);
      pclk = 1'b0;
    end
    pdio = ~pdio;
    step(8);
  endtask : ser_frame
  task automatic t_ser;
    for (int i = 0; i < 3; i++) ser_frame(1'b0, 1'b0, addrs[i], words[i]);
    ser_frame(1'b0, 1'b1, addrs[2], msk(words[2]));
    ser_frame(1'b1, 1'b1, addrs[1], msk(words[1]));
    {prog_mode, dbg_mode} = 2'b00;
    $display("test serial done");
  endtask : t_ser
  task automatic t_fetch;
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    chk(32'(fetch_addr), 32'(RESET_VECTOR));
    run = 1'b1;
    step(1);
    chk({instr_valid, instr_word, fetch_addr[14:0]}, {1'b1, msk(words[0]), 15'h1});
    {jump, jump_pc} = {1'b1, addrs[1]};
    step(1);
    {run, jump} = 2'b00;
    chk(32'({instr_word, fetch_addr}), 32'({msk(words[1]), addrs[1] + 16'h1}));
    chk(32'(instr_valid), 32'h1);
    step(1);
    chk(32'(taken), 32'd2);
    $display("test fetch done");
  endtask : t_fetch
  task automatic t_table;
    logic [15:0] w;
    wr(2'h0, OFS_TBL_PTR_LO, 8'h06);
    wr(2'h0, OFS_TBL_PTR_HI, 8'h01);
    for (int k = 0; k < 4; k++) begin
      w = msk(words[(k >= 2) ? 2 : 1]);
      tbl = '{1'b1, mmt_tbl_kind_type'(k), 2'h2, 8'(8'h90 + k)};
      {run, jump, jump_pc} = {2'b11, 16'h0};
      step(1);
      tbl.req = 1'b0;
      chk(32'({tbl_done, fetch_stall}), 32'h3);
      step(1);
      {run, jump} = 2'b00;
      chk(32'(tbl_done), 32'h0);
      rdc(k[0] ? 2'h2 : 2'h0, 8'(8'h90 + k), w[7:0]);
      rdc(2'h0, OFS_TBL_HOLD, w[15:8]);
    end
    $display("test table done");
  endtask : t_table
  task automatic t_regs;
    wr(2'h0, OFS_TBL_HOLD, 8'h3c);
    rdc(2'h2, OFS_TBL_HOLD, 8'h3c);
    wr(2'h1, OFS_NVM_CTRL, 8'hff);
    rdc(2'h1, OFS_NVM_CTRL, NVM_CTRL_WR_MASK);
    chk(32'(nvm_ctrl), 32'(NVM_CTRL_WR_MASK));
    wr(2'h0, OFS_NVM_CTRL, 8'h00);
    rdc(2'h1, OFS_NVM_CTRL, NVM_CTRL_WR_MASK);
    rdc(2'h0, OFS_NVM_CTRL, UNUSED_READ);
    wr(2'h0, 8'h0f, 8'ha5);
    rdc(2'h0, 8'h0f, UNUSED_READ);
    $display("test registers done");
  endtask : t_regs
  task automatic t_gp;
    for (int s = 0; s < 3; s++) begin
      wr(2'(s), 8'hff, 8'(8'h10 + s));
      wr(2'(s), OFS_GP_BASE, 8'(8'h20 + s));
    end
    for (int s = 0; s < 3; s++) begin
      rdc(2'(s), 8'hff, 8'(8'h10 + s));
      rdc(2'(s), OFS_GP_BASE, 8'(8'h20 + s));
    end
    dmop(4'h2, 3'h7, 2'h1, 8'hff, 8'h00);
    rdc(2'h1, 8'hff, 8'h91);
    dmop(4'h1, 3'h4, 2'h1, 8'hff, 8'h00);
    rdc(2'h1, 8'hff, 8'h81);
    $display("test general storage done");
  endtask : t_gp
  task automatic t_ind;
    wr(2'h0, OFS_PTR_FIRST, 8'ha0);
    wr(2'h2, OFS_IND_FIRST, 8'h66);
    rdc(2'h0, 8'ha0, 8'h66);
    wr(2'h0, OFS_PTR_SECOND_LO, 8'ha1);
    wr(2'h0, OFS_PTR_SECOND_HI, 8'h02);
    wr(2'h0, OFS_IND_SECOND, 8'h77);
    rdc(2'h2, 8'ha1, 8'h77);
    wr(2'h0, OFS_PTR_THIRD_LO, 8'ha2);
    wr(2'h0, OFS_PTR_THIRD_HI, 8'h01);
    wr(2'h0, OFS_IND_THIRD, 8'h44);
    rdc(2'h1, 8'ha2, 8'h44);
    $display("test indirect done");
  endtask : t_ind
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    step(12);
    srst = 1'b0;
    t_ser;
    t_fetch;
    t_table;
    t_regs;
    t_gp;
    t_ind;
    wrap_up;
  end
  // whole run needs about 1750 cycles; allow ample margin
  initial begin
    #200000;
    n_fail++;
    wrap_up;
  end
endmodule : tb_top

bind mmt_top mmt_chk #(.PROG_DEPTH(PROG_DEPTH), .PROG_WIDTH(PROG_WIDTH)) chk_i (
  .clk(clk), .srst(srst), .fetch(fetch), .instr_word(instr_word), .instr_valid(instr_valid),
  .fetch_addr(fetch_addr), .fetch_stall(fetch_stall), .tbl(tbl), .tbl_done(tbl_done),
  .dm(dm), .dm_rvalid(dm_rvalid), .nvm_ctrl(nvm_ctrl));
